// file: src/stc_top.sv
// 16-bit standard timer: control registers, counter, capture, axi4-lite slave
// assumes pins are synchronous to core_clk and a single axi4-lite master
//
// Functional notes
// - pause bit freezes counter, clearing resumes
// - clock select picks system, divided or pin
// - code 101 gives no counter clock
// - on rising clears counter, falling holds it
// - timer off: counter idle, low power
// - on rising resets compare output level
// - control 0 low three bits read zero
// - mode field selects four operating modes
// - match A: hold, low, high, toggle
// - pwm function: inactive, active, pwm, pulse
// - capture edge: rise, fall, both, none
// - requested equals initial level: no change
// - counter read-only, compare A read/write, controls
// - output control sets initial level/active polarity
// - polarity bit inverts pin level
// - swap bit exchanges period and duty comparators
// - clear select: match A, or P/overflow
`timescale 1ns/100ps
`default_nettype none
module stc_top
  import stc_pkg::*;
#(
  parameter int unsigned TBC_DIV = 256
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_clock_pin,
  input  wire logic        timer_pin_a_in,
  output logic             timer_pin_a_out,
  output logic             timer_pin_a_oe,
  output logic             timer_pin_b_out,
  output logic             timer_pin_b_oe
);

  typedef struct packed {
    logic        pause;
    logic [2:0]  cksel;
    logic        on;
    logic        on_prev;
    logic [7:0]  ctrl1;
    logic [15:0] count;
    logic [15:0] cmpa;
    logic [7:0]  cmpp;
    logic        cap_prev;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stc_top_state_type;

  stc_top_state_type s;
  stc_top_state_type next_s;

  logic        tick;
  logic        on_rise;
  logic        run;
  logic [1:0]  mode;
  logic [1:0]  func;
  logic [15:0] inc;
  logic [15:0] p_full;
  logic [15:0] period_val;
  logic [15:0] duty_val;
  logic        a_hit;
  logic        p_hit;
  logic        period_hit;
  logic        clr;
  logic        cap_edge;
  logic        wr_fire;
  logic        pin_q;
  logic        oe_q;

  stc_ctl_if ctl ();

  stc_clk_sel #(
    .TBC_DIV (TBC_DIV)
  ) u_clk_sel (
    .core_clk           (core_clk),
    .rst                (rst),
    .clock_select       (s.cksel),
    .external_clock_pin (external_clock_pin),
    .tick               (tick)
  );

  stc_out u_out (
    .core_clk (core_clk),
    .rst      (rst),
    .ctl      (ctl),
    .pin      (pin_q),
    .pin_oe   (oe_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter and comparators

  assign mode       = s.ctrl1[MODE_LSB +: 2];
  assign func       = s.ctrl1[FUNC_LSB +: 2];
  assign on_rise    = s.on & ~s.on_prev;
  // tick is one cycle late, so a fresh undefined select is gated here too
  assign run        = s.on & ~s.pause & tick & (s.cksel != CKSEL_UNDEF);
  assign inc        = s.count + 16'h0001;
  // period comparator sees only the high byte; zero means full overflow
  assign p_full     = {s.cmpp, 8'h00};
  assign period_val = s.ctrl1[SWAP_BIT] ? s.cmpa : p_full;
  assign duty_val   = s.ctrl1[SWAP_BIT] ? p_full : s.cmpa;
  assign a_hit      = (inc == s.cmpa);
  assign p_hit      = (inc == p_full);
  assign period_hit = (inc == period_val);
  assign clr        = (mode == MODE_PWM) ? period_hit
                    : (s.ctrl1[CLR_BIT] ? a_hit : p_hit);

  always_comb begin
    case (func)
      FUNC_0:  cap_edge = timer_pin_a_in & ~s.cap_prev;
      FUNC_1:  cap_edge = ~timer_pin_a_in & s.cap_prev;
      FUNC_2:  cap_edge = timer_pin_a_in ^ s.cap_prev;
      default: cap_edge = 1'b0;
    endcase
  end

  assign ctl.mode       = mode;
  assign ctl.func       = func;
  assign ctl.oc         = s.ctrl1[OC_BIT];
  assign ctl.pol        = s.ctrl1[POL_BIT];
  assign ctl.on_rise    = on_rise;
  assign ctl.a_hit      = run & a_hit;
  assign ctl.period_hit = run & period_hit;
  assign ctl.under_duty = s.count < duty_val;

  ////////////////////////////////////////////////////////////////////////////
  // register read decode

  function automatic logic [32:0] read_reg(input logic [7:0] addr);
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    case (word)
      ADDR_CTRL0:   read_reg = {1'b1, 24'h000000, s.pause, s.cksel, s.on, 3'b000};
      ADDR_CTRL1:   read_reg = {1'b1, 24'h000000, s.ctrl1};
      ADDR_CNT_LO:  read_reg = {1'b1, 24'h000000, s.count[7:0]};
      ADDR_CNT_HI:  read_reg = {1'b1, 24'h000000, s.count[15:8]};
      ADDR_CMPA_LO: read_reg = {1'b1, 24'h000000, s.cmpa[7:0]};
      ADDR_CMPA_HI: read_reg = {1'b1, 24'h000000, s.cmpa[15:8]};
      ADDR_CMPP:    read_reg = {1'b1, 24'h000000, s.cmpp};
      default:      read_reg = {1'b0, 32'h00000000};
    endcase
  endfunction : read_reg

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [32:0] rd;
  logic [32:0] wr_map;
  logic [7:0]  wword;

  always_comb begin
    next_s          = s;
    rd              = read_reg(s_axi_araddr);
    wr_map          = 33'h000000000;
    wword           = 8'h00;
    wr_fire         = 1'b0;
    next_s.on_prev  = s.on;
    next_s.cap_prev = timer_pin_a_in;

    if (on_rise) begin
      next_s.count = COUNT_RESET;
    end else if (run) begin
      next_s.count = clr ? COUNT_RESET : inc;
    end

    // write channels are taken independently, in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full  = 1'b1;
      next_s.w_data  = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.aw_full && next_s.w_full && !s.bvalid) begin
      wr_fire        = 1'b1;
      wword          = {next_s.aw_addr[7:2], 2'b00};
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      if (next_s.w_lane0) begin
        case (wword)
          ADDR_CTRL0: begin
            next_s.pause = next_s.w_data[PAUSE_BIT];
            next_s.cksel = next_s.w_data[CKSEL_LSB +: 3];
            next_s.on    = next_s.w_data[ON_BIT];
          end
          ADDR_CTRL1:   next_s.ctrl1      = next_s.w_data;
          ADDR_CMPA_LO: next_s.cmpa[7:0]  = next_s.w_data;
          ADDR_CMPA_HI: next_s.cmpa[15:8] = next_s.w_data;
          ADDR_CMPP:    next_s.cmpp       = next_s.w_data;
          default:      next_s.bvalid     = 1'b1;
        endcase
      end
      // unmapped offsets answer with an error, mapped ones always okay
      wr_map = read_reg(next_s.aw_addr);
      if (!wr_map[32]) begin
        next_s.bresp = RESP_SLVERR;
      end
    end

    // a capture lands after any same-cycle bus write, so it is never lost
    if (mode == MODE_CAP && s.on && cap_edge) begin
      next_s.cmpa = s.count;
    end

    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd[31:0];
      next_s.rresp  = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end

    next_s.awready = ~next_s.aw_full & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_full & ~next_s.bvalid;
    next_s.arready = ~next_s.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s         <= '0;
      s.ctrl1   <= CTRL_RESET;
      s.count   <= COUNT_RESET;
      s.cmpa    <= CMPA_RESET;
      s.cmpp    <= CMPP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready   = s.awready;
  assign s_axi_wready    = s.wready;
  assign s_axi_bresp     = s.bresp;
  assign s_axi_bvalid    = s.bvalid;
  assign s_axi_arready   = s.arready;
  assign s_axi_rdata     = s.rdata;
  assign s_axi_rresp     = s.rresp;
  assign s_axi_rvalid    = s.rvalid;
  // both pins carry the same timer output
  assign timer_pin_a_out = pin_q;
  assign timer_pin_a_oe  = oe_q;
  assign timer_pin_b_out = pin_q;
  assign timer_pin_b_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_pause_hold: assert property (@(posedge core_clk) disable iff (rst)
    s.pause && !on_rise |=> $stable(s.count))
    else $error("counter moved while paused");

  a_sel_undef: assert property (@(posedge core_clk) disable iff (rst)
    s.cksel == CKSEL_UNDEF && !on_rise |=> $stable(s.count))
    else $error("counter moved with undefined clock");

  a_on_clear: assert property (@(posedge core_clk) disable iff (rst)
    on_rise |=> s.count == COUNT_RESET)
    else $error("timer on did not clear counter");

  a_off_hold: assert property (@(posedge core_clk) disable iff (rst)
    !s.on ##1 !s.on |-> $stable(s.count))
    else $error("counter moved while off");

  a_ctrl0_zero: assert property (@(posedge core_clk) disable iff (rst)
    s_axi_arvalid && s.arready && s_axi_araddr[7:2] == ADDR_CTRL0[7:2]
    |=> s_axi_rvalid && s_axi_rdata[2:0] == 3'b000 && s_axi_rdata[31:8] == 24'h000000)
    else $error("control 0 read showed unimplemented bits");

  a_count_step: assert property (@(posedge core_clk) disable iff (rst)
    run && !clr && !on_rise |=> s.count == $past(s.count) + 16'h0001)
    else $error("counter did not step by one");

  a_capture_off: assert property (@(posedge core_clk) disable iff (rst)
    mode == MODE_CAP && func == FUNC_3 && !wr_fire |=> $stable(s.cmpa))
    else $error("capture happened while disabled");

endmodule : stc_top
`default_nettype wire

// file: src/stc_pkg.sv
// constants of the 16-bit standard timer block: register map, fields, codes
// assumes a single core clock; used by every timer module through import
package stc_pkg;

  // register byte addresses on the 32-bit register bus
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO  = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h0c;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
  localparam logic [7:0] ADDR_CMPP    = 8'h18;

  // field positions
  localparam int PAUSE_BIT = 7;
  localparam int CKSEL_LSB = 4;
  localparam int ON_BIT    = 3;
  localparam int MODE_LSB  = 6;
  localparam int FUNC_LSB  = 4;
  localparam int OC_BIT    = 3;
  localparam int POL_BIT   = 2;
  localparam int SWAP_BIT  = 1;
  localparam int CLR_BIT   = 0;

  // values after reset
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CMPA_RESET  = 16'h0000;
  localparam logic [7:0]  CMPP_RESET  = 8'h00;

  // clock select codes
  localparam logic [2:0] CKSEL_SYS4     = 3'h0;
  localparam logic [2:0] CKSEL_SYS      = 3'h1;
  localparam logic [2:0] CKSEL_HI16     = 3'h2;
  localparam logic [2:0] CKSEL_HI64     = 3'h3;
  localparam logic [2:0] CKSEL_TBC      = 3'h4;
  localparam logic [2:0] CKSEL_UNDEF    = 3'h5;
  localparam logic [2:0] CKSEL_EXT_RISE = 3'h6;
  localparam logic [2:0] CKSEL_EXT_FALL = 3'h7;

  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  // output function codes
  localparam logic [1:0] FUNC_0 = 2'h0;
  localparam logic [1:0] FUNC_1 = 2'h1;
  localparam logic [1:0] FUNC_2 = 2'h2;
  localparam logic [1:0] FUNC_3 = 2'h3;

  // prescaler taps
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [5:0] DIV64_LAST = 6'h3f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : stc_pkg

// file: src/stc_ctl_if.sv
// settings and events passed from the timer core to the pin output unit
// assumes both ends run on core_clk
`timescale 1ns/100ps
`default_nettype none
interface stc_ctl_if;
  logic [1:0] mode;
  logic [1:0] func;
  logic       oc;
  logic       pol;
  logic       on_rise;
  logic       a_hit;
  logic       period_hit;
  logic       under_duty;

  modport timer (output mode, func, oc, pol, on_rise, a_hit, period_hit, under_duty);
  modport pins  (input  mode, func, oc, pol, on_rise, a_hit, period_hit, under_duty);
endinterface : stc_ctl_if
`default_nettype wire

// file: src/stc_clk_sel.sv
// counter clock enable: prescaler taps, timebase divider, external pin edges
// assumes external_clock_pin is already synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module stc_clk_sel
  import stc_pkg::*;
#(
  parameter int unsigned TBC_DIV = 256
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [2:0] clock_select,
  input  wire logic       external_clock_pin,
  output logic            tick
);

  typedef struct packed {
    logic [5:0]  pre;
    logic [15:0] tbc;
    logic        ext_prev;
    logic        tick;
  } stc_clk_state_type;

  stc_clk_state_type s;
  stc_clk_state_type next_s;

  always_comb begin
    next_s          = s;
    next_s.pre      = s.pre + 6'h01;
    next_s.ext_prev = external_clock_pin;
    next_s.tbc      = (s.tbc == 16'(TBC_DIV - 1)) ? 16'h0000 : s.tbc + 16'h0001;
    // high clock taken as the core clock; one tap pulse per divided period
    case (clock_select)
      CKSEL_SYS4:     next_s.tick = (s.pre[1:0] == DIV4_LAST);
      CKSEL_SYS:      next_s.tick = 1'b1;
      CKSEL_HI16:     next_s.tick = (s.pre[3:0] == DIV16_LAST);
      CKSEL_HI64:     next_s.tick = (s.pre == DIV64_LAST);
      CKSEL_TBC:      next_s.tick = (s.tbc == 16'(TBC_DIV - 1));
      CKSEL_EXT_RISE: next_s.tick = external_clock_pin & ~s.ext_prev;
      CKSEL_EXT_FALL: next_s.tick = ~external_clock_pin & s.ext_prev;
      default:        next_s.tick = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

  a_ext_rise_tick: assert property (@(posedge core_clk) disable iff (rst)
    clock_select == CKSEL_EXT_RISE && external_clock_pin && !s.ext_prev |=> tick)
    else $error("external rising edge gave no counter tick");

endmodule : stc_clk_sel
`default_nettype wire

// file: src/stc_out.sv
// timer pin output unit: compare match levels, pwm and single pulse
// assumes events arrive as one-cycle pulses from the timer core
`timescale 1ns/100ps
`default_nettype none
module stc_out
  import stc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  stc_ctl_if.pins   ctl,
  output logic      pin,
  output logic      pin_oe
);

  typedef struct packed {
    logic level;
    logic pulse_live;
    logic pin;
    logic oe;
  } stc_out_state_type;

  stc_out_state_type s;
  stc_out_state_type next_s;
  logic              active;

  always_comb begin
    next_s = s;
    active = 1'b0;
    case (ctl.mode)
      MODE_CMP: begin
        if (ctl.on_rise) begin
          next_s.level = ctl.oc;
        end else if (ctl.a_hit) begin
          // same level as before gives no visible change
          case (ctl.func)
            FUNC_1:  next_s.level = 1'b0;
            FUNC_2:  next_s.level = 1'b1;
            FUNC_3:  next_s.level = ~s.level;
            default: next_s.level = s.level;
          endcase
        end
        next_s.pin = next_s.level ^ ctl.pol;
        next_s.oe  = 1'b1;
      end
      MODE_PWM: begin
        if (ctl.on_rise) begin
          next_s.pulse_live = 1'b1;
        end else if (ctl.period_hit) begin
          next_s.pulse_live = 1'b0;
        end
        case (ctl.func)
          FUNC_0:  active = 1'b0;
          FUNC_1:  active = 1'b1;
          FUNC_2:  active = ctl.under_duty;
          default: active = s.pulse_live;
        endcase
        next_s.level = active ? ctl.oc : ~ctl.oc;
        next_s.pin   = next_s.level ^ ctl.pol;
        next_s.oe    = 1'b1;
      end
      default: begin
        // capture and plain timer modes leave the pin to its other owner
        next_s.pin = 1'b0;
        next_s.oe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin    = s.pin;
  assign pin_oe = s.oe;

  a_init_level: assert property (@(posedge core_clk) disable iff (rst)
    ctl.mode == MODE_CMP && ctl.on_rise |=> pin == $past(ctl.oc ^ ctl.pol) && pin_oe)
    else $error("pin not at initial level after timer on");

  a_match_low: assert property (@(posedge core_clk) disable iff (rst)
    ctl.mode == MODE_CMP && !ctl.on_rise && ctl.a_hit && ctl.func == FUNC_1
    |=> pin == $past(ctl.pol))
    else $error("compare match did not drive low");

  a_pwm_forced: assert property (@(posedge core_clk) disable iff (rst)
    ctl.mode == MODE_PWM && ctl.func == FUNC_0 |=> pin == $past(~ctl.oc ^ ctl.pol))
    else $error("forced inactive level wrong");

  a_timer_undriven: assert property (@(posedge core_clk) disable iff (rst)
    ctl.mode == MODE_TMR |=> !pin_oe)
    else $error("pin driven in timer mode");

endmodule : stc_out
`default_nettype wire

// file: verification/stc_pin_model.sv
// far-side pin model: external count clock bursts and capture input level
// assumes start is a one-cycle request from the bench
`timescale 1ns/100ps
`default_nettype none
module stc_pin_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] n_pulses,
  input  wire logic       start,
  input  wire logic       cap_level,
  output logic            external_clock_pin,
  output logic            timer_pin_a_in
);
  logic [9:0] phase = 10'h0;

  // four cycles per pulse; idle low so no stray edge is counted
  always @(posedge core_clk) begin
    if (start) begin
      phase <= {n_pulses, 2'h0};
    end else if (phase != 10'h0) begin
      phase <= phase - 10'h1;
    end
  end
  assign external_clock_pin = phase[1];
  assign timer_pin_a_in     = cap_level;
endmodule : stc_pin_model
`default_nettype wire

// file: verification/standard_timer_control_regs_test.sv
// self-checking bench of the timer block through its register bus
// assumes stc_pkg and the pin model are compiled first
`timescale 1ns/100ps
`default_nettype none
module standard_timer_control_regs_test;
  import stc_pkg::*;
  logic        core_clk = 1'h0;
  logic        rst      = 1'h1;
  logic [7:0]  awaddr   = 8'h0;
  logic [7:0]  araddr   = 8'h0;
  logic [7:0]  n_pulses = 8'h0;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'h0;
  logic        wvalid   = 1'h0;
  logic        bready   = 1'h0;
  logic        arvalid  = 1'h0;
  logic        rready   = 1'h0;
  logic        start    = 1'h0;
  logic        cap_lvl  = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, ext_pin, pin_in;
  logic        pa, pa_oe, pb, pb_oe;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd_val;
  int          bad_count = 0;
  int          n_tests = 0;
  // window bounds per clock select code, window of about 643 cycles, or 9 pin pulses for codes 6 and 7
  int lo_tab[8] = '{158, 640, 39, 9, 158, 0, 9, 9};
  int hi_tab[8] = '{163, 648, 42, 11, 163, 0, 9, 9};

  stc_top #(.TBC_DIV(4)) DUT (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_clock_pin(ext_pin), .timer_pin_a_in(pin_in),
    .timer_pin_a_out(pa), .timer_pin_a_oe(pa_oe), .timer_pin_b_out(pb), .timer_pin_b_oe(pb_oe)
  );
  stc_pin_model far (
    .core_clk(core_clk), .n_pulses(n_pulses), .start(start), .cap_level(cap_lvl),
    .external_clock_pin(ext_pin), .timer_pin_a_in(pin_in)
  );

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task rng(input logic [31:0] got, input int lo, input int hi);
    n_tests++;
    if ($isunknown(got) || got < lo || got > hi) begin
      bad_count++;
      $display("ERROR %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : rng

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    resp = bresp;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd_val = rdata;
    resp = rresp;
  endtask : rd

  // counter is paused or stopped here, so the two byte reads cannot tear
  task rd_cnt(output logic [15:0] c);
    rd(ADDR_CNT_LO);
    c[7:0] = rd_val[7:0];
    rd(ADDR_CNT_HI);
    c[15:8] = rd_val[7:0];
  endtask : rd_cnt

  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      chk(rd_val, 32'h0);
    end
    rd(8'h1c);
    chk({rd_val[29:0], resp}, {30'h0, RESP_SLVERR});
    wr(8'h1c, 8'h00);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(ADDR_CTRL0, 8'hff);
    rd(ADDR_CTRL0);
    chk(rd_val, 32'hf8);
    wr(ADDR_CNT_LO, 8'h55);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(ADDR_CNT_LO);
    chk(rd_val, 32'h0);
    wr(ADDR_CMPA_HI, 8'ha5);
    rd(ADDR_CMPA_HI);
    chk(rd_val, 32'ha5);
    wr(ADDR_CMPP, 8'h3c);
    rd(ADDR_CMPP);
    chk(rd_val, 32'h3c);
    wr(ADDR_CMPP, 8'h00);
  endtask : t_regs

  task t_rates;
    logic [15:0] c1, c2, c3;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_CTRL0, {1'h0, 3'(k), 4'h8});
      if (k >= 6) begin
        @(posedge core_clk);
        n_pulses <= 8'h09;
        start    <= 1'h1;
        @(posedge core_clk);
        start    <= 1'h0;
        repeat (50) @(posedge core_clk);
      end else begin
        repeat (640) @(posedge core_clk);
      end
      wr(ADDR_CTRL0, {1'h1, 3'(k), 4'h8});
      rd_cnt(c1);
      rng({16'h0, c1}, lo_tab[k], hi_tab[k]);
      wr(ADDR_CTRL0, {1'h0, 3'(k), 4'h8});
      wr(ADDR_CTRL0, {1'h1, 3'(k), 4'h8});
      rd_cnt(c2);
      rng({16'h0, c2}, int'(c1), int'(c1) + ((k == 1) ? 16 : 4));
      wr(ADDR_CTRL0, {1'h0, 3'(k), 4'h0});
      rd_cnt(c3);
      repeat (20) @(posedge core_clk);
      rd_cnt(c2);
      chk({16'h0, c2}, {16'h0, c3});
    end
  endtask : t_rates

  task t_cmp;
    logic [7:0] cfg[6] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h09, 8'h25};
    logic [1:0] exp[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h2};
    wr(ADDR_CMPA_HI, 8'h00);
    wr(ADDR_CMPA_LO, 8'hc8);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, cfg[i]);
      wr(ADDR_CTRL0, 8'h18);
      repeat (3) @(posedge core_clk);
      chk({29'h0, pa_oe, pa, pb}, {29'h0, 1'h1, {2{exp[i][1]}}});
      repeat (300) @(posedge core_clk);
      chk({30'h0, pa, pb}, {30'h0, {2{exp[i][0]}}});
    end
  endtask : t_cmp

  task t_pwm;
    // period 2048 cycles outlasts the window; the single pulse uses the short
    // swapped period of 8 so that its end falls inside the 64 samples
    logic [7:0] cfg[5] = '{8'h88, 8'h98, 8'ha8, 8'hba, 8'haa};
    int lo[5] = '{0, 64, 5, 5, 62};
    int hi[5] = '{0, 64, 7, 7, 64};
    logic [7:0] hc;
    wr(ADDR_CMPP, 8'h08);
    wr(ADDR_CMPA_LO, 8'h08);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, cfg[i]);
      wr(ADDR_CTRL0, 8'h18);
      repeat (3) @(posedge core_clk);
      hc = 8'h0;
      repeat (64) begin
        @(posedge core_clk);
        hc = hc + {7'h0, pa};
      end
      rng({24'h0, hc}, lo[i], hi[i]);
    end
  endtask : t_pwm

  task t_cap;
    logic [7:0] v1;
    wr(ADDR_CMPP, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, {2'h1, 2'(f), 4'h0});
      wr(ADDR_CMPA_LO, 8'h00);
      wr(ADDR_CTRL0, 8'h18);
      repeat (20) @(posedge core_clk);
      cap_lvl <= 1'h1;
      repeat (5) @(posedge core_clk);
      rd(ADDR_CMPA_LO);
      v1 = rd_val[7:0];
      chk(32'(v1 !== 8'h0), 32'(f == 0 || f == 2));
      cap_lvl <= 1'h0;
      repeat (5) @(posedge core_clk);
      rd(ADDR_CMPA_LO);
      chk(32'(rd_val[7:0] !== v1), 32'(f == 1 || f == 2));
    end
  endtask : t_cap

  task t_tmr;
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, {7'h60, 1'(j)});
      wr(ADDR_CMPP, 8'h01);
      wr(ADDR_CMPA_LO, 8'h03);
      wr(ADDR_CTRL0, 8'h18);
      repeat (50) @(posedge core_clk);
      rd(ADDR_CNT_LO);
      // clear on P match needs 256 counts, so it is not reached in 50 cycles
      rng(rd_val, (j == 0) ? 48 : 0, (j == 0) ? 54 : 2);
      chk({30'h0, pa_oe, pb_oe}, 32'h0);
    end
  endtask : t_tmr

  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    t_regs();
    t_rates();
    t_cmp();
    t_pwm();
    t_cap();
    t_tmr();
    wrap_up();
  end
endmodule : standard_timer_control_regs_test
`default_nettype wire
